// *** hdl/lmt_pkg.sv ***
// Constants shared by the life monitor and monitor trim block.
package lmt_pkg;

   // ==========================================================
   // Register map, byte addresses on the plain register port.
   localparam int unsigned AW       = 5;
   localparam logic [4:0]  ADR_CTRL = 5'h00;
   localparam logic [4:0]  ADR_STAT = 5'h04;
   localparam logic [4:0]  ADR_EVT  = 5'h08;
   localparam logic [4:0]  ADR_MASK = 5'h0C;
   localparam logic [4:0]  ADR_CMD  = 5'h10;
   localparam logic [4:0]  ADR_TRIM = 5'h14;
   localparam logic [4:0]  ADR_LIFE = 5'h18;

   // ==========================================================
   // Control register fields.
   localparam int unsigned CTRL_WEN     = 0;
   localparam int unsigned CTRL_ALLOC   = 1;
   localparam int unsigned ALLOC_W      = 2;
   localparam int unsigned CTRL_WP      = 3;
   localparam int unsigned CTRL_RESTART = 4;
   localparam int unsigned CTRL_INIT    = 5;
   localparam int unsigned NPIN         = 3;

   // ==========================================================
   // Event register fields, shared by the mask register.
   localparam int unsigned EVT_WARN = 0;
   localparam int unsigned EVT_DUE  = 1;
   localparam int unsigned EVT_REJ  = 2;
   localparam int unsigned EVT_W    = 3;

   // ==========================================================
   // Trim step command fields.
   localparam int unsigned CMD_CH   = 0;
   localparam int unsigned CMD_GAIN = 1;
   localparam int unsigned CMD_DEC  = 2;

   // ==========================================================
   // Life estimates in percent.
   localparam logic [6:0] LIFE_THR = 7'h0A;
   localparam logic [6:0] LIFE_NEW = 7'h64;

   // ==========================================================
   // Trim code limits, factory codes and scaling.
   localparam logic signed [7:0] GAIN_MIN  = -8'sd125;
   localparam logic signed [7:0] GAIN_MAX  = 8'sd125;
   localparam logic signed [7:0] OFS_MIN   = -8'sd127;
   localparam logic signed [7:0] OFS_MAX   = 8'sd127;
   localparam logic signed [7:0] FACT_OFS  = 8'sh00;
   localparam logic signed [7:0] FACT_GAIN = 8'sh00;
   localparam int OFS_STEP_UV   = 18900;
   localparam int DAC_LSB_UV    = 305;
   localparam int OFS_STEP_DAC  = (OFS_STEP_UV + DAC_LSB_UV / 2) / DAC_LSB_UV;
   localparam int GAIN_STEP_PPM = 4000;
   localparam int GAIN_ONE_Q16  = 65536;
   localparam int GAIN_STEP_Q16 = GAIN_STEP_PPM * GAIN_ONE_Q16 / 1000000;
   localparam int MON_MAX       = 32767;
   localparam int MON_MIN       = -32768;

endpackage

// *** hdl/lmt_trim_mem.sv ***
// Store of the four monitor trim codes with saturating single steps.
`timescale 1ns/100ps
module lmt_trim_mem (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              step_i,
   input  wire logic [1:0]        sel_i,
   input  wire logic              dec_i,
   output logic [3:0][7:0]        code_o
);

   // ==========================================================
   // Entries 0 and 1 are channel offsets, entries 2 and 3 channel gains.
   logic signed [7:0] code_q [4];
   logic signed [7:0] code_d [4];

   for (genvar e = 0; e < 4; e++) begin : g_ent
      localparam logic signed [7:0] LO  = (e >= 2) ? lmt_pkg::GAIN_MIN : lmt_pkg::OFS_MIN;
      localparam logic signed [7:0] HI  = (e >= 2) ? lmt_pkg::GAIN_MAX : lmt_pkg::OFS_MAX;
      localparam logic signed [7:0] FAC = (e >= 2) ? lmt_pkg::FACT_GAIN : lmt_pkg::FACT_OFS;

      // One step up or down on the addressed entry, held at its limit.
      always_comb begin
         code_d[e] = code_q[e];
         if (step_i && sel_i == 2'(e)) begin
            if (dec_i && code_q[e] > LO) begin
               code_d[e] = code_q[e] - 8'sd1;
            end else if (!dec_i && code_q[e] < HI) begin
               code_d[e] = code_q[e] + 8'sd1;
            end
         end
      end

      // Factory codes are in effect from reset until a step replaces them.
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            code_q[e] <= FAC;
         end else begin
            code_q[e] <= code_d[e];
         end
      end

      assign code_o[e] = code_q[e];

      // A code never leaves its own range.
      property p_range;
         @(posedge clk_i) disable iff (!rst_n_i)
         code_q[e] >= LO && code_q[e] <= HI;
      endproperty
      a_range: assert property (p_range) else $error("trim code out of range");
   end

endmodule

// *** hdl/lmt_top.sv ***
// Life monitor with maintenance warning, due output and monitor trim.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps

// Overview of operation
// - Warning raised while any of four life estimates is at or below 10%.
// - Warning enable: 0 default suppresses, 1 detects; takes effect on restart.
// - Maintenance due asserted while any estimate is at or below 10%.
// - Due output follows the threshold even with warnings disabled, if allocated.
// - Due contact closed at or below threshold, open only when all exceed 10%.
// - Due output drives a pin only once allocated; otherwise no pin driven.
// - Estimates read 100% when new, fall with use, reach 0% at replacement.
// - Signed offset trim per monitor output, 18.9 mV per step, about 2.4 V.
// - Gain is 100% plus 0.4% per signed step, spanning 50% to 150%.
// - Trim codes live apart from settings; settings init leaves them alone.
// - Trim step commands are rejected while write protection is on.
// - Two channels, each with offset and gain code, stepped by +1 or -1.
// - Factory trim codes hold until a user adjustment replaces them.
module lmt_top (
   input  wire logic               CLOCK_I,
   input  wire logic               RST_N_I,
   input  wire logic [4:0]         ADDR_I,
   input  wire logic [31:0]        WDATA_I,
   input  wire logic               WR_I,
   input  wire logic               RD_I,
   output logic [31:0]             RDATA_O,
   output logic                    IRQ_O,
   input  wire logic [6:0]         LIFE_FAN_I,
   input  wire logic [6:0]         LIFE_CAP_I,
   input  wire logic [6:0]         LIFE_INRUSH_I,
   input  wire logic [6:0]         LIFE_BRAKE_I,
   input  wire logic signed [15:0] MON1_I,
   input  wire logic signed [15:0] MON2_I,
   output logic signed [15:0]      MON1_O,
   output logic signed [15:0]      MON2_O,
   output logic                    WARN_O,
   output logic [2:0]              DUE_PIN_O,
   output logic [2:0]              DUE_PIN_OE_O
);

   // ==========================================================
   // Life estimate comparison.
   logic [6:0] life_raw [4];
   logic [6:0] life_c   [4];
   logic [3:0] low;
   logic       any_low;

   assign life_raw[0] = LIFE_FAN_I;
   assign life_raw[1] = LIFE_CAP_I;
   assign life_raw[2] = LIFE_INRUSH_I;
   assign life_raw[3] = LIFE_BRAKE_I;

   // Clamp each estimate to 100% and compare it against the threshold.
   for (genvar i = 0; i < 4; i++) begin : g_life
      assign life_c[i] = (life_raw[i] > lmt_pkg::LIFE_NEW) ? lmt_pkg::LIFE_NEW
                                                          : life_raw[i];
      assign low[i]    = (life_c[i] <= lmt_pkg::LIFE_THR);
   end
   assign any_low = |low;

   // ==========================================================
   // Register port decode.
   logic wr_ctrl;
   logic wr_mask;
   logic wr_cmd;
   logic rd_evt;
   logic step;
   logic reject;

   assign wr_ctrl = WR_I && ADDR_I == lmt_pkg::ADR_CTRL;
   assign wr_mask = WR_I && ADDR_I == lmt_pkg::ADR_MASK;
   assign wr_cmd  = WR_I && ADDR_I == lmt_pkg::ADR_CMD;
   assign rd_evt  = RD_I && ADDR_I == lmt_pkg::ADR_EVT;

   // ==========================================================
   // Settings: warning enable, pin allocation, write protection.
   logic                        wen_set_q, wen_set_d;
   logic                        wen_act_q, wen_act_d;
   logic                        wp_q, wp_d;
   logic [lmt_pkg::ALLOC_W-1:0] alloc_q, alloc_d;

   // Settings init restores defaults but never touches the trim store.
   always_comb begin
      wen_set_d = wen_set_q;
      wen_act_d = wen_act_q;
      wp_d      = wp_q;
      alloc_d   = alloc_q;
      if (wr_ctrl && WDATA_I[lmt_pkg::CTRL_INIT]) begin
         wen_set_d = 1'b0;
         wp_d      = 1'b0;
         alloc_d   = '0;
      end else if (wr_ctrl) begin
         wen_set_d = WDATA_I[lmt_pkg::CTRL_WEN];
         wp_d      = WDATA_I[lmt_pkg::CTRL_WP];
         alloc_d   = WDATA_I[lmt_pkg::CTRL_ALLOC +: lmt_pkg::ALLOC_W];
      end
      if (wr_ctrl && WDATA_I[lmt_pkg::CTRL_RESTART]) begin
         wen_act_d = wen_set_q;
      end
   end

   // Settings registers; reset leaves warnings disabled.
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         wen_set_q <= 1'b0;
         wen_act_q <= 1'b0;
         wp_q      <= 1'b0;
         alloc_q   <= '0;
      end else begin
         wen_set_q <= wen_set_d;
         wen_act_q <= wen_act_d;
         wp_q      <= wp_d;
         alloc_q   <= alloc_d;
      end
   end

   // ==========================================================
   // Warning, due output and pin allocation.
   logic                      warn_q, warn_d;
   logic                      due_q, due_d;
   logic [lmt_pkg::NPIN-1:0] pin_q, pin_d;
   logic [lmt_pkg::NPIN-1:0] oe_q, oe_d;

   // The due level ignores the warning enable; pins follow the allocation.
   always_comb begin
      warn_d = wen_act_q && any_low;
      due_d  = any_low;
      for (int k = 0; k < lmt_pkg::NPIN; k++) begin
         oe_d[k]  = (alloc_q == lmt_pkg::ALLOC_W'(k + 1));
         pin_d[k] = oe_d[k] && any_low;
      end
   end

   // Output flops.
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         warn_q <= 1'b0;
         due_q  <= 1'b0;
         pin_q  <= '0;
         oe_q   <= '0;
      end else begin
         warn_q <= warn_d;
         due_q  <= due_d;
         pin_q  <= pin_d;
         oe_q   <= oe_d;
      end
   end

   assign WARN_O       = warn_q;
   assign DUE_PIN_O    = pin_q;
   assign DUE_PIN_OE_O = oe_q;

   // ==========================================================
   // Trim store and step commands.
   logic [3:0][7:0] code;

   assign step   = wr_cmd && !wp_q;
   assign reject = wr_cmd && wp_q;

   lmt_trim_mem u_mem (
      .clk_i   (CLOCK_I),
      .rst_n_i (RST_N_I),
      .step_i  (step),
      .sel_i   ({WDATA_I[lmt_pkg::CMD_GAIN], WDATA_I[lmt_pkg::CMD_CH]}),
      .dec_i   (WDATA_I[lmt_pkg::CMD_DEC]),
      .code_o  (code)
   );

   // ==========================================================
   // Monitor output trim: gain in Q16, offset in converter steps.
   logic signed [15:0] mon_in [2];
   logic signed [15:0] mon_q  [2];
   logic signed [15:0] mon_d  [2];

   assign mon_in[0] = MON1_I;
   assign mon_in[1] = MON2_I;

   for (genvar c = 0; c < 2; c++) begin : g_mon
      logic signed [7:0]  ofs;
      logic signed [7:0]  gcode;
      logic signed [17:0] g;
      logic signed [33:0] p;
      logic signed [19:0] s;

      assign ofs   = code[c];
      assign gcode = code[c + 2];
      assign g     = $signed(18'(lmt_pkg::GAIN_ONE_Q16 + gcode * lmt_pkg::GAIN_STEP_Q16));
      assign p     = mon_in[c] * g;
      assign s     = $signed(20'(p >>> 16)) + $signed(20'(ofs * lmt_pkg::OFS_STEP_DAC));

      // Saturate the trimmed sample to the converter range.
      always_comb begin
         if (s > lmt_pkg::MON_MAX) begin
            mon_d[c] = 16'sh7FFF;
         end else if (s < lmt_pkg::MON_MIN) begin
            mon_d[c] = -16'sh8000;
         end else begin
            mon_d[c] = s[15:0];
         end
      end

      // Trimmed sample register.
      always_ff @(posedge CLOCK_I) begin
         if (!RST_N_I) begin
            mon_q[c] <= 16'sh0000;
         end else begin
            mon_q[c] <= mon_d[c];
         end
      end
   end

   assign MON1_O = mon_q[0];
   assign MON2_O = mon_q[1];

   // ==========================================================
   // Events, mask and interrupt.
   logic [lmt_pkg::EVT_W-1:0] evt_q, evt_d;
   logic [lmt_pkg::EVT_W-1:0] mask_q, mask_d;
   logic [lmt_pkg::EVT_W-1:0] set;
   logic                      irq_q, irq_d;

   // A new event wins over the clear caused by reading the event register.
   always_comb begin
      set                   = '0;
      set[lmt_pkg::EVT_WARN] = warn_d && !warn_q;
      set[lmt_pkg::EVT_DUE]  = due_d && !due_q;
      set[lmt_pkg::EVT_REJ]  = reject;
      evt_d  = (rd_evt ? '0 : evt_q) | set;
      mask_d = wr_mask ? WDATA_I[lmt_pkg::EVT_W-1:0] : mask_q;
      irq_d  = |(evt_d & mask_d);
   end

   // Event and mask registers.
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         evt_q  <= '0;
         mask_q <= '0;
         irq_q  <= 1'b0;
      end else begin
         evt_q  <= evt_d;
         mask_q <= mask_d;
         irq_q  <= irq_d;
      end
   end

   assign IRQ_O = irq_q;

   // ==========================================================
   // Read data, valid only in the cycle after the read strobe.
   logic [31:0] rdata_q, rdata_d;

   // Read multiplexer; unmapped addresses read zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (RD_I) begin
         unique case (ADDR_I)
            lmt_pkg::ADR_CTRL: begin
               rdata_d[lmt_pkg::CTRL_WEN]                     = wen_set_q;
               rdata_d[lmt_pkg::CTRL_ALLOC +: lmt_pkg::ALLOC_W] = alloc_q;
               rdata_d[lmt_pkg::CTRL_WP]                      = wp_q;
            end
            lmt_pkg::ADR_STAT: rdata_d[2:0] = {wen_act_q, due_q, warn_q};
            lmt_pkg::ADR_EVT:  rdata_d[lmt_pkg::EVT_W-1:0] = evt_q;
            lmt_pkg::ADR_MASK: rdata_d[lmt_pkg::EVT_W-1:0] = mask_q;
            lmt_pkg::ADR_TRIM: rdata_d = code;
            lmt_pkg::ADR_LIFE: begin
               rdata_d = {1'b0, life_c[3], 1'b0, life_c[2], 1'b0, life_c[1], 1'b0, life_c[0]};
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_O = rdata_q;

   // ==========================================================
   // Checks.
   property p_warn;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      wen_act_q && any_low |=> WARN_O;
   endproperty
   a_warn: assert property (p_warn) else $error("warning missed");

   property p_wen;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      !(wr_ctrl && WDATA_I[lmt_pkg::CTRL_RESTART]) |=> $stable(wen_act_q) || !$past(RST_N_I);
   endproperty
   a_wen: assert property (p_wen) else $error("enable changed without restart");

   property p_wen_off;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      !wen_act_q |=> !WARN_O;
   endproperty
   a_wen_off: assert property (p_wen_off) else $error("warning while disabled");

   property p_due;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      any_low |=> due_q;
   endproperty
   a_due: assert property (p_due) else $error("due not asserted");

   property p_pin;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      alloc_q == 2'h1 && any_low && !wen_act_q |=> DUE_PIN_O[0] && DUE_PIN_OE_O[0];
   endproperty
   a_pin: assert property (p_pin) else $error("allocated pin not closed");

   property p_open;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      !any_low |=> !due_q && DUE_PIN_O == 3'h0;
   endproperty
   a_open: assert property (p_open) else $error("contact closed with good life");

   property p_alloc;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      alloc_q == 2'h0 |=> DUE_PIN_OE_O == 3'h0 && DUE_PIN_O == 3'h0;
   endproperty
   a_alloc: assert property (p_alloc) else $error("pin driven without allocation");

   property p_init;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      wr_ctrl && WDATA_I[lmt_pkg::CTRL_INIT] |=> $stable(code) && !wen_set_q;
   endproperty
   a_init: assert property (p_init) else $error("init disturbed trim");

   property p_prot;
      @(posedge CLOCK_I) disable iff (!RST_N_I)
      wr_cmd && wp_q |=> $stable(code) && evt_q[lmt_pkg::EVT_REJ];
   endproperty
   a_prot: assert property (p_prot) else $error("protected step not rejected");

endmodule

// *** tb/lmt_host_model.sv ***
// Host controller model that reads the maintenance due contacts.
`timescale 1ns/100ps
module lmt_host_model (
   input  wire logic [2:0] pin_i,
   input  wire logic [2:0] pin_oe_i,
   output logic [2:0]      closed_o
);
   // A pin that the drive leaves undriven reads as an open contact at the host.
   always_comb begin
      closed_o = pin_i & pin_oe_i;
   end
endmodule

// *** tb/tb.sv ***
// Self-checking testbench for the life monitor and monitor trim block.
`timescale 1ns/100ps
module tb;
   typedef struct packed {
      logic [27:0] life;
      logic [1:0]  alloc;
      logic        warn;
      logic [2:0]  cls;
      logic [2:0]  oe;
   } lmt_row_s;
   logic                clk;
   logic                rst_n = 1'b0;
   logic                wr    = 1'b0;
   logic                rd    = 1'b0;
   logic [4:0]          addr  = 5'h00;
   logic [31:0]         wdata = 32'h0;
   logic [31:0]         rdata;
   logic [31:0]         rv;
   logic                irq;
   logic                warn;
   logic [27:0]         life  = {7'h64, 7'h64, 7'h64, 7'h64};
   logic signed [15:0]  m1i   = 16'sh0000;
   logic signed [15:0]  m2i   = 16'sh0000;
   logic signed [15:0]  m1o;
   logic signed [15:0]  m2o;
   logic [2:0]          pin;
   logic [2:0]          oe;
   logic [2:0]          closed;
   int                  err_count    = 0;
   int                  total_checks = 0;
   int                  cyc          = 0;
   lmt_row_s            rows [7] = '{
      '{{7'h64, 7'h64, 7'h64, 7'h64}, 2'h1, 1'b0, 3'h0, 3'h1},
      '{{7'h0A, 7'h64, 7'h64, 7'h64}, 2'h1, 1'b1, 3'h1, 3'h1},
      '{{7'h64, 7'h0B, 7'h64, 7'h64}, 2'h2, 1'b0, 3'h0, 3'h2},
      '{{7'h64, 7'h64, 7'h0A, 7'h64}, 2'h2, 1'b1, 3'h2, 3'h2},
      '{{7'h64, 7'h64, 7'h64, 7'h00}, 2'h3, 1'b1, 3'h4, 3'h4},
      '{{7'h0B, 7'h0B, 7'h0B, 7'h0B}, 2'h3, 1'b0, 3'h0, 3'h4},
      '{{7'h7F, 7'h64, 7'h05, 7'h64}, 2'h0, 1'b1, 3'h0, 3'h0}};

   lmt_top lmt_top_i (.CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .LIFE_FAN_I(life[27:21]),
      .LIFE_CAP_I(life[20:14]), .LIFE_INRUSH_I(life[13:7]), .LIFE_BRAKE_I(life[6:0]),
      .MON1_I(m1i), .MON2_I(m2i), .MON1_O(m1o), .MON2_O(m2o), .WARN_O(warn),
      .DUE_PIN_O(pin), .DUE_PIN_OE_O(oe));
   lmt_host_model lmt_host_model_i (.pin_i(pin), .pin_oe_i(oe), .closed_o(closed));

   // ==========================================================
   // Clock, timeout and shared tasks.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Cuts a hung run short well past the expected length.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         $display("ERROR %0t: timeout", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask

   // Expected trimmed monitor sample, saturated to the output width.
   function automatic logic [31:0] mon_exp(input int x, input int g, input int o);
      longint p;
      p = (longint'(x) * (lmt_pkg::GAIN_ONE_Q16 + g * lmt_pkg::GAIN_STEP_Q16)) >>> 16;
      p = p + o * lmt_pkg::OFS_STEP_DAC;
      if (p > lmt_pkg::MON_MAX) p = lmt_pkg::MON_MAX;
      if (p < lmt_pkg::MON_MIN) p = lmt_pkg::MON_MIN;
      return {16'h0000, p[15:0]};
   endfunction

   // ==========================================================
   // Main sequence.
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(lmt_pkg::ADR_STAT, rv);
      chk(rv, 32'h0, "status after reset");
      rd_reg(lmt_pkg::ADR_TRIM, rv);
      chk(rv, 32'h0, "factory trim");
      rd_reg(5'h1C, rv);
      chk(rv, 32'h0, "unmapped read");
      $display("test reset done");
      wr_reg(lmt_pkg::ADR_MASK, 32'h7);
      wr_reg(lmt_pkg::ADR_CTRL, 32'h3);
      life <= {7'h05, 7'h64, 7'h64, 7'h64};
      @(posedge clk);
      #1 chk(warn, 32'h0, "warn before restart");
      chk(closed, 32'h1, "due with warn off");
      @(posedge clk);
      #1 chk(irq, 32'h1, "irq on due rise");
      @(posedge clk);
      rd_reg(lmt_pkg::ADR_EVT, rv);
      chk(rv, 32'h2, "due rise event");
      #1 chk(irq, 32'h0, "irq after clear");
      @(posedge clk);
      wr_reg(lmt_pkg::ADR_CTRL, 32'h13);
      #1 chk(warn, 32'h1, "warn after restart");
      @(posedge clk);
      rd_reg(lmt_pkg::ADR_EVT, rv);
      chk(rv, 32'h1, "warn rise event");
      $display("test enable done");
      foreach (rows[i]) begin
         wr_reg(lmt_pkg::ADR_CTRL, {29'h0, rows[i].alloc, 1'b1});
         life <= rows[i].life;
         @(posedge clk);
         #1 chk(warn, rows[i].warn, "row warn");
         chk(oe, rows[i].oe, "row drive");
         chk(closed, rows[i].cls, "row contact");
         @(posedge clk);
         rd_reg(lmt_pkg::ADR_STAT, rv);
         chk(rv, {29'h0, 1'b1, rows[i].warn, rows[i].warn}, "row status");
      end
      rd_reg(lmt_pkg::ADR_LIFE, rv);
      chk(rv, 32'h64056464, "life clamp");
      $display("test table done");
      life <= {7'h64, 7'h64, 7'h64, 7'h64};
      m1i  <= 16'sh03E8;
      m2i  <= 16'shF830;
      wr_reg(lmt_pkg::ADR_CMD, 32'h2);
      wr_reg(lmt_pkg::ADR_CMD, 32'h5);
      rd_reg(lmt_pkg::ADR_TRIM, rv);
      chk(rv, 32'h0001FF00, "single steps");
      #1 chk({16'h0, m1o}, mon_exp(1000, 1, 0), "gain step");
      chk({16'h0, m2o}, mon_exp(-2000, 0, -1), "offset step");
      @(posedge clk);
      m1i <= 16'sh7D00;
      repeat (130) wr_reg(lmt_pkg::ADR_CMD, 32'h0);
      repeat (128) wr_reg(lmt_pkg::ADR_CMD, 32'h7);
      rd_reg(lmt_pkg::ADR_TRIM, rv);
      chk(rv, 32'h8301FF7F, "saturated codes");
      #1 chk({16'h0, m1o}, mon_exp(32000, 1, 127), "output clamp");
      chk({16'h0, m2o}, mon_exp(-2000, -125, -1), "half gain");
      @(posedge clk);
      $display("test trim done");
      rd_reg(lmt_pkg::ADR_EVT, rv);
      wr_reg(lmt_pkg::ADR_MASK, 32'h4);
      rd_reg(lmt_pkg::ADR_MASK, rv);
      chk(rv, 32'h4, "mask readback");
      wr_reg(lmt_pkg::ADR_CTRL, 32'h9);
      wr_reg(lmt_pkg::ADR_CMD, 32'h2);
      rd_reg(lmt_pkg::ADR_TRIM, rv);
      chk(rv, 32'h8301FF7F, "protected step");
      #1 chk(irq, 32'h1, "irq on refusal");
      @(posedge clk);
      rd_reg(lmt_pkg::ADR_EVT, rv);
      chk(rv, 32'h4, "refusal event");
      wr_reg(lmt_pkg::ADR_CTRL, 32'h3F);
      rd_reg(lmt_pkg::ADR_CTRL, rv);
      chk(rv, 32'h0, "settings init");
      rd_reg(lmt_pkg::ADR_TRIM, rv);
      chk(rv, 32'h8301FF7F, "trim kept on init");
      $display("test protect done");
      repeat (255) wr_reg(lmt_pkg::ADR_CMD, 32'h4);
      repeat (251) wr_reg(lmt_pkg::ADR_CMD, 32'h3);
      rd_reg(lmt_pkg::ADR_TRIM, rv);
      #1 chk(rdata, 32'h0, "read data drops");
      chk(rv, 32'h7D01FF81, "opposite limits");
      chk({16'h0, m1o}, mon_exp(32000, 1, -127), "negative offset");
      chk({16'h0, m2o}, mon_exp(-2000, 125, -1), "full gain");
      $display("test limit done");
      tally_and_finish();
   end
endmodule
